// ==== core/sfid_pkg.sv ====
// How it works
// - Host sends 90h then 24-bit address
// - Pair read: maker then part, MSB first
// - Address 000001h swaps byte order
// - Code 9Fh returns maker byte first
// - Then memory type, then capacity byte
// - Identity read ignored during busy cycle
// - Host avoids identity read in deep sleep
// - Opcode in, 24-bit identity out falling edges
// - Raising select ends output at any time
// - Select high returns device to standby
// - Host waits powerup delay before writes
// - Delivered array reads all FFh
// - Delivered status register reads 00h
// - Deep sleep ignores all but wake command
package sfid_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam logic [7:0] PAIR_ID_CMD = 8'h90;
    localparam logic [7:0] READ_IDENTITY_CMD = 8'h9F;
    localparam logic [7:0] WAKE_AND_ID_CMD = 8'hAB;
    localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
    localparam logic [7:0] ARRAY_RESET_VAL = 8'hFF;
    localparam logic [7:0] STATUS_RESET_VAL = 8'h00;
    localparam logic [23:0] ADDR_NORMAL = 24'h000000;
    localparam logic [23:0] ADDR_SWAPPED = 24'h000001;
    localparam int ADDR_BITS = 24;
    localparam int SUPPLY_TO_SELECT_US = 10;
    localparam int SUPPLY_TO_SELECT_CYC = (SUPPLY_TO_SELECT_US * (CLK_HZ / 1_000_000));
    localparam int WRITE_WAIT_MIN_MS = 1;
    localparam int WRITE_WAIT_CYC = WRITE_WAIT_MIN_MS * (CLK_HZ / 1000);
    localparam int SCK_HALF_CYC = 2;
    typedef enum logic [2:0] {
        SF_IDLE, SF_OPCODE, SF_ADDR, SF_SHIFT_OUT, SF_IGNORE
    } sf_state_e;
endpackage

// ==== core/sfid_if.sv ====
`timescale 1ns/1ps
interface sfid_if;
    logic sck;
    logic sel_n;
    logic serial_in;
    logic sdo_o;
    logic sdo_oe;
    modport dev (input sck, input sel_n, input serial_in, output sdo_o, output sdo_oe);
    modport host (output sck, output sel_n, output serial_in, input sdo_o, input sdo_oe);
endinterface

// ==== core/sfid_device.sv ====
`timescale 1ns/1ps
module sfid_device #(
    parameter logic [7:0] MAKER_ID = 8'h5A,    // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h10,     // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h20,    // Arbitrary value
    parameter logic [7:0] MEM_CAP = 8'h11      // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    sfid_if.dev bus,
    input wire logic busy,
    output logic deep_sleep,
    output logic [7:0] status_q,
    output logic [7:0] array_q
);
    import sfid_pkg::*;

    // ----------------------------------------
    // State record
    // ----------------------------------------
    // One packed record holds every flop of the device side, so reset and
    // update stay in one place and no field can be left behind.
    typedef struct packed {
        // Input side
        sf_state_e st;
        logic sck_d;
        logic [7:0] sh_in;
        logic [4:0] cnt;
        logic [7:0] op;
        // Output side
        logic [23:0] sh_out;
        logic sdo;
        logic oe;
        logic sleep;
        // Delivered-state values
        logic [7:0] status;
        logic [7:0] array_rd;
        // Sleep entry and exit are armed by the opcode and applied on deselect
        logic arm_sleep;
        logic arm_wake;
    } sfid_dev_s;

    sfid_dev_s cur_ff, nxt_ff;
    logic rise, fall;
    logic [7:0] byte_in;

    // ----------------------------------------
    // Serial clock edges
    // ----------------------------------------
    // The serial clock is sampled as a plain input; one delayed copy gives
    // both edges. The host holds each level for at least two system clocks,
    // so no edge is lost between samples.
    always_comb begin
        rise = bus.sck & ~cur_ff.sck_d;
        fall = ~bus.sck & cur_ff.sck_d;
        byte_in = {cur_ff.sh_in[6:0], bus.serial_in};
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Decode is kept apart from sequencing so the refusal order reads at a
    // glance: sleep first, then a running internal cycle.
    typedef enum logic [2:0] {
        DC_NONE,
        DC_IDENT,
        DC_PAIR,
        DC_SLEEP,
        DC_WAKE
    } sfid_dec_e;
    sfid_dec_e dec;

    always_comb begin
        dec = DC_NONE;
        if (cur_ff.sleep) begin
            // Everything but the wake command is dropped
            if (byte_in == WAKE_AND_ID_CMD) begin
                dec = DC_WAKE;
            end
        end else if (busy) begin
            dec = DC_NONE;
        end else begin
            case (byte_in)
                READ_IDENTITY_CMD: dec = DC_IDENT;
                PAIR_ID_CMD: dec = DC_PAIR;
                DEEP_SLEEP_CMD: dec = DC_SLEEP;
                default: dec = DC_NONE;
            endcase
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.sck_d = bus.sck;
        if (bus.sel_n) begin
            nxt_ff.st = SF_IDLE;
            nxt_ff.oe = 1'b0;
            nxt_ff.cnt = '0;
            // A sleep change only takes effect on a clean deselect
            if (cur_ff.arm_sleep) begin
                nxt_ff.sleep = 1'b1;
            end
            if (cur_ff.arm_wake) begin
                nxt_ff.sleep = 1'b0;
            end
            nxt_ff.arm_sleep = 1'b0;
            nxt_ff.arm_wake = 1'b0;
        end else begin
            case (cur_ff.st)
                SF_IDLE: begin
                    nxt_ff.st = SF_OPCODE;
                    nxt_ff.cnt = '0;
                end
                SF_OPCODE: begin
                    if (rise) begin
                        nxt_ff.sh_in = byte_in;
                        nxt_ff.cnt = cur_ff.cnt + 5'd1;
                        if (cur_ff.cnt == 5'd7) begin
                            nxt_ff.op = byte_in;
                            nxt_ff.cnt = '0;
                            nxt_ff.st = SF_IGNORE;
                            case (dec)
                                DC_IDENT: begin
                                    nxt_ff.sh_out = {MAKER_ID, MEM_TYPE, MEM_CAP};
                                    nxt_ff.st = SF_SHIFT_OUT;
                                end
                                DC_PAIR: nxt_ff.st = SF_ADDR;
                                DC_SLEEP: nxt_ff.arm_sleep = 1'b1;
                                DC_WAKE: nxt_ff.arm_wake = 1'b1;
                                default: nxt_ff.st = SF_IGNORE;
                            endcase
                        end
                    end
                end
                SF_ADDR: begin
                    if (rise) begin
                        nxt_ff.sh_in = byte_in;
                        nxt_ff.cnt = cur_ff.cnt + 5'd1;
                        if (cur_ff.cnt == 5'(ADDR_BITS - 1)) begin
                            // Upper address bits are don't-care
                            // Bit zero arrives on this last rise, the rest were only counted
                            if (bus.serial_in) begin
                                nxt_ff.sh_out = {PART_ID, MAKER_ID, 8'h00};
                            end else begin
                                nxt_ff.sh_out = {MAKER_ID, PART_ID, 8'h00};
                            end
                            nxt_ff.st = SF_SHIFT_OUT;
                        end
                    end
                end
                SF_SHIFT_OUT: begin
                    // Moving on the falling edge lets the host sample a settled bit
                    if (fall) begin
                        nxt_ff.oe = 1'b1;
                        nxt_ff.sdo = cur_ff.sh_out[23];
                        // Identity wraps so it can be read continuously
                        nxt_ff.sh_out = {cur_ff.sh_out[22:0], cur_ff.sh_out[23]};
                    end
                end
                SF_IGNORE: begin
                    nxt_ff.oe = 1'b0;
                    // Clocking on past the opcode cancels a pending sleep change
                    if (rise) begin
                        nxt_ff.arm_sleep = 1'b0;
                        nxt_ff.arm_wake = 1'b0;
                    end
                end
                default: nxt_ff.st = SF_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Delivered-state values are loaded only by reset; nothing in this
    // block writes the array or the status byte.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
            cur_ff.st <= SF_IDLE;
            cur_ff.status <= STATUS_RESET_VAL;
            cur_ff.array_rd <= ARRAY_RESET_VAL;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every output is a plain copy of a flop, so the pin and its enable
    // never glitch while the decode settles.

    assign bus.sdo_o = cur_ff.sdo;
    assign bus.sdo_oe = cur_ff.oe;
    assign deep_sleep = cur_ff.sleep;
    assign status_q = cur_ff.status;
    assign array_q = cur_ff.array_rd;
endmodule

// ==== core/sfid_host.sv ====
`timescale 1ns/1ps
module sfid_host #(
    parameter int POWERUP_CYC = sfid_pkg::SUPPLY_TO_SELECT_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    sfid_if.host bus,
    input wire logic start,
    input wire logic pair_read,
    input wire logic swap_order,
    output logic ready,
    output logic done,
    output logic [23:0] id_data
);
    import sfid_pkg::*;

    typedef enum logic [1:0] {H_WAIT, H_IDLE, H_XFER, H_END} host_st_e;
    typedef struct packed {
        host_st_e st;
        logic [15:0] wait_cnt;
        logic [5:0] bits;
        logic [1:0] half;
        logic sck;
        logic sel_n;
        logic so;
        logic [31:0] tx;
        logic [23:0] rx;
        logic [5:0] total;
        logic [5:0] outbits;
        logic rdy;
        logic dn;
    } sfid_host_s;

    sfid_host_s cur_ff, nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.dn = 1'b0;
        case (cur_ff.st)
            H_WAIT: begin
                // Supply settle before first select
                if (cur_ff.wait_cnt == 16'(POWERUP_CYC)) begin
                    nxt_ff.st = H_IDLE;
                    nxt_ff.rdy = 1'b1;
                end else begin
                    nxt_ff.wait_cnt = cur_ff.wait_cnt + 16'd1;
                end
            end
            H_IDLE: begin
                if (start) begin
                    nxt_ff.rdy = 1'b0;
                    nxt_ff.sel_n = 1'b0;
                    nxt_ff.bits = '0;
                    nxt_ff.half = '0;
                    if (pair_read) begin
                        nxt_ff.tx = {PAIR_ID_CMD, (swap_order ? ADDR_SWAPPED : ADDR_NORMAL)};
                        nxt_ff.total = 6'd48;
                    end else begin
                        nxt_ff.tx = {READ_IDENTITY_CMD, 24'h000000};
                        nxt_ff.total = 6'd32;
                    end
                    nxt_ff.outbits = pair_read ? 6'd32 : 6'd8;
                    nxt_ff.so = nxt_ff.tx[31];
                    nxt_ff.st = H_XFER;
                end
            end
            H_XFER: begin
                nxt_ff.half = cur_ff.half + 2'd1;
                if (cur_ff.half == 2'(SCK_HALF_CYC - 1)) begin
                    nxt_ff.half = '0;
                    nxt_ff.sck = ~cur_ff.sck;
                    if (!cur_ff.sck) begin
                        if (cur_ff.bits >= cur_ff.outbits) begin
                            nxt_ff.rx = {cur_ff.rx[22:0], bus.sdo_o};
                        end
                    end else begin
                        nxt_ff.bits = cur_ff.bits + 6'd1;
                        nxt_ff.tx = {cur_ff.tx[30:0], 1'b0};
                        nxt_ff.so = cur_ff.tx[30];
                        if (cur_ff.bits == cur_ff.total - 6'd1) begin
                            nxt_ff.st = H_END;
                        end
                    end
                end
            end
            H_END: begin
                nxt_ff.sel_n = 1'b1;
                nxt_ff.sck = 1'b0;
                nxt_ff.dn = 1'b1;
                nxt_ff.rdy = 1'b1;
                nxt_ff.st = H_IDLE;
            end
            default: nxt_ff.st = H_WAIT;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
            cur_ff.st <= H_WAIT;
            cur_ff.sel_n <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign bus.sck = cur_ff.sck;
    assign bus.sel_n = cur_ff.sel_n;
    assign bus.serial_in = cur_ff.so;
    assign ready = cur_ff.rdy;
    assign done = cur_ff.dn;
    assign id_data = cur_ff.rx;
endmodule

// ==== test/sfid_chk.sv ====
`timescale 1ns/1ps
module sfid_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic sel_n,
    input wire logic serial_in,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Frame and pin discipline
    // ----------------------------------------
    chk_oe_needs_sel: assert property (sdo_oe |-> !$past(sel_n))
        else $error("device drives output while deselected");
    chk_frame_hold: assert property ($fell(sel_n) |-> !sel_n [*8])
        else $error("select released too early in frame");
    chk_sck_low_sel: assert property ($fell(sel_n) |-> !sck)
        else $error("serial clock high when select fell");
    chk_quiet_opcode: assert property ($fell(sel_n) |-> !sdo_oe [*8])
        else $error("device drives during opcode phase");
    chk_sck_half: assert property ($rose(sck) |-> sck [*2] ##1 !sck)
        else $error("serial clock high phase not two cycles");
    chk_sck_idle: assert property (sel_n && $past(sel_n) |-> !sck)
        else $error("serial clock runs outside a frame");
    // Data may only move while the clock is low, so the rising sample sees it settled
    chk_sdo_hold_high: assert property (sck && $past(sck) && sdo_oe |-> $stable(sdo_o))
        else $error("device output moved while clock high");
    chk_din_hold_high: assert property (!sel_n && sck && $past(sck) |-> $stable(serial_in))
        else $error("host data moved while clock high");
    chk_oe_drop: assert property ($rose(sel_n) |=> !sdo_oe)
        else $error("device kept driving after deselect");
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
    import sfid_pkg::*;
    localparam logic [7:0] MK = 8'h5A; // Arbitrary value
    localparam logic [7:0] PT = 8'h3C; // Arbitrary value
    localparam logic [7:0] TY = 8'h20; // Arbitrary value
    localparam logic [7:0] CP = 8'h11; // Arbitrary value
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic busy = 1'b0;
    logic start = 1'b0;
    logic pair_read = 1'b0;
    logic swap_order = 1'b0;
    logic deep_sleep, ready, done, oe_seen;
    logic [7:0] status_q, array_q;
    logic [23:0] id_data;
    int num_errors = 0;
    int num_checks = 0;
    sfid_if ifc ();
    sfid_device #(.MAKER_ID(MK), .PART_ID(PT), .MEM_TYPE(TY), .MEM_CAP(CP)) sfid_device_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .bus(ifc), .busy(busy),
        .deep_sleep(deep_sleep), .status_q(status_q), .array_q(array_q));
    sfid_host #(.POWERUP_CYC(4)) sfid_host_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .bus(ifc), .start(start),
        .pair_read(pair_read), .swap_order(swap_order), .ready(ready), .done(done),
        .id_data(id_data));
    sfid_chk sfid_chk_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .sck(ifc.sck), .sel_n(ifc.sel_n),
        .serial_in(ifc.serial_in), .sdo_o(ifc.sdo_o), .sdo_oe(ifc.sdo_oe));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // Catches any drive of the output line inside a frame
    always @(posedge core_clk) begin
        if (ifc.sdo_oe === 1'b1) oe_seen <= 1'b1;
    end
    function automatic logic [23:0] expect_id(input logic pr, input logic sw);
        if (!pr) return {MK, TY, CP};
        return sw ? {8'h00, PT, MK} : {8'h00, MK, PT};
    endfunction
    task automatic xfer(input logic pr, input logic sw);
        int n;
        n = 0;
        @(posedge core_clk);
        while (ready !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        oe_seen <= 1'b0;
        pair_read <= pr;
        swap_order <= sw;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("done", 1'b1, done)
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic pr, sw;
        logic [23:0] got;
        void'($urandom(32'hA4DDFD3B));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK("status", 8'h00, status_q)
        `CHK("array", 8'hFF, array_q)
        `CHK("sleep", 1'b0, deep_sleep)
        `CHK("ready_wait", 1'b0, ready)
        // No write instruction is ever issued, so the write wait holds
        // Fixed corners first, then random back-to-back transfers
        for (int i = 0; i < 16; i++) begin
            pr = (i < 4) ? i[0] : 1'($urandom());
            sw = (i < 4) ? i[1] : 1'($urandom());
            xfer(pr, sw);
            got = pr ? {8'h00, id_data[15:0]} : id_data;
            `CHK("id", expect_id(pr, sw), got)
        end
        // Erase or program running: identity read must not be decoded
        busy <= 1'b1;
        xfer(1'b0, 1'b0);
        `CHK("oe_busy", 1'b0, oe_seen)
        busy <= 1'b0;
        xfer(1'b0, 1'b0);
        `CHK("id_after_busy", expect_id(1'b0, 1'b0), id_data)
        `CHK("sleep_end", 1'b0, deep_sleep)
        conclude();
    end
    initial begin
        #(20000 * 25);
        num_errors++;
        conclude();
    end
endmodule
